// File: rtl/psg_pkg.sv
// package of constants for the programmable sound generator
// assumes: one clock, command bytes arrive from a host over a parallel bus
`default_nettype none
package psg_pkg;

  // ==========================================================
  // register widths and reset values
  localparam int          PERIOD_W     = 10;
  localparam int          ATT_W        = 4;
  localparam int          NCFG_W       = 3;
  localparam int          LFSR_W       = 15;
  localparam int          SAMPLE_W     = 8;
  localparam int          LEVEL_W      = 6;
  localparam int          NUM_TONE     = 3;
  localparam int          NUM_CHAN     = 4;
  localparam logic [9:0]  PERIOD_RST   = 10'h000;
  localparam logic [3:0]  ATT_RST      = 4'hF;
  localparam logic [2:0]  NCFG_RST     = 3'h0;
  localparam logic [14:0] LFSR_SEED    = 15'h4000;

  // ==========================================================
  // command byte fields
  localparam int          CMD_LATCH_B  = 7;
  localparam int          CMD_CH_HI    = 6;
  localparam int          CMD_CH_LO    = 5;
  localparam int          CMD_TYPE_B   = 4;
  localparam int          CMD_DATA_HI  = 5;
  localparam int          NCFG_WHITE_B = 2;
  localparam logic [1:0]  NOISE_CH     = 2'h3;
  localparam logic [1:0]  RATE_TONE2   = 2'h3;

  // ==========================================================
  // prescaler pick codes and ratios
  localparam logic [1:0]  PICK_DIV1    = 2'h1;
  localparam logic [1:0]  PICK_DIV128  = 2'h2;
  localparam int          DIV16        = 16;
  localparam int          DIV128       = 128;
  localparam int          PRESC_W      = 7;
  // noise shift rates 512, 1024, 2048 are counted in divide-by-16 ticks
  localparam int          NOISE_CLK    = 512;
  localparam int          NOISE_BASE   = NOISE_CLK / DIV16;
  localparam int          NOISE_CNT_W  = 7;

  // ==========================================================
  // attenuation: 16 levels, 2 dB apart, 0 is loudest
  function automatic logic [5:0] psg_level(input logic [3:0] att);
    case (att)
      4'h0:    psg_level = 6'h3F;
      4'h1:    psg_level = 6'h32;
      4'h2:    psg_level = 6'h28;
      4'h3:    psg_level = 6'h20;
      4'h4:    psg_level = 6'h19;
      4'h5:    psg_level = 6'h14;
      4'h6:    psg_level = 6'h10;
      4'h7:    psg_level = 6'h0D;
      4'h8:    psg_level = 6'h0A;
      4'h9:    psg_level = 6'h08;
      4'hA:    psg_level = 6'h06;
      4'hB:    psg_level = 6'h05;
      4'hC:    psg_level = 6'h04;
      4'hD:    psg_level = 6'h03;
      4'hE:    psg_level = 6'h03;
      default: psg_level = 6'h02;
    endcase
  endfunction : psg_level

endpackage : psg_pkg
`default_nettype wire

// File: rtl/psg_fifo_if.sv
// carrier between the command capture and the command fifo
// assumes: both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface psg_fifo_if #(parameter int WIDTH = 8);
  logic             inValid;
  logic             inReady;
  logic [WIDTH-1:0] inData;
  logic             outValid;
  logic             outReady;
  logic [WIDTH-1:0] outData;
  modport fifo (input inValid, inData, outReady,
                output inReady, outValid, outData);
  modport user (output inValid, inData, outReady,
                input inReady, outValid, outData);
endinterface : psg_fifo_if
`default_nettype wire

// File: rtl/psg_fifo.sv
// small flip-flop fifo for command bytes
// assumes: synchronous active-low reset, one clock
`timescale 1ns/100ps
`default_nettype none
module psg_fifo
  import psg_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stream ports
  psg_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign f.inReady  = (count_reg != (AW+1)'(DEPTH));
  assign f.outValid = (count_reg != '0);
  assign f.outData  = mem[rdPtr_reg];
  assign push       = f.inValid && f.inReady;
  assign pop        = f.outValid && f.outReady;

  // ==========================================================
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= f.inData;
    end
  end

  // ==========================================================
  // pointers and fill count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : psg_fifo
`default_nettype wire

// File: rtl/psg_core.sv
// programmable sound generator: three tones, one noise, digital mix
// assumes: host holds data stable around a low write strobe
//
// Operation
// - eight write-only settings: four attenuations, three periods, noise cfg
// - tone counter counts down, reloads period at one, flips output
// - noise bit comes from a 15-bit shift register
// - noise rate code picks 512, 1024, 2048 or tone channel 2
// - byte 11100bff loads noise type and rate code
// - attenuation has 16 levels, 2 dB apart, zero loudest
// - channels 0-2 square tones, channel 3 noise, each attenuated
// - four attenuated channels summed into master signal
// - master given as 8-bit sample and as pwm bit
// - each channel also has its own pwm output
// - channel waveforms swing between 0 and level, no offset
// - always ready; every write completes in one cycle
// - single clock, synchronous reset clears registers except fifo storage, sets attenuations to 15, write strobe synchronisers to 1, and seeds noise
// - byte 1cc0ffff writes low 4 period bits of channel cc
// - byte 00ffffff writes high 6 period bits
// - byte 1cc1aaaa writes attenuation of channel cc
// - pick pins: 00/11 divide 16, 01 none, 10 divide 128
// - tone frequency is clock over period times 32, 2 or 256
`timescale 1ns/100ps
`default_nettype none
module psg_core
  import psg_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // host bus pins
  input  wire logic [7:0]          dataBus,
  input  wire logic                writeN,
  input  wire logic                prescale_pick_lo,
  input  wire logic                prescale_pick_hi,
  // audio outputs
  output logic [SAMPLE_W-1:0]      sample,
  output logic                     audioPwm,
  output logic [NUM_CHAN-1:0]      chanPwm,
  // command path status
  output logic                     cmdReady
);

  // ==========================================================
  // pin synchronisers
  logic [7:0] dataS1_reg;
  logic [7:0] dataS2_reg;
  logic       weS1_reg;
  logic       weS2_reg;
  logic       weS3_reg;
  logic [1:0] pickS1_reg;
  logic [1:0] pickS2_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dataS1_reg <= '0;
      dataS2_reg <= '0;
      weS1_reg   <= 1'b1;
      weS2_reg   <= 1'b1;
      weS3_reg   <= 1'b1;
      pickS1_reg <= '0;
      pickS2_reg <= '0;
    end else begin
      dataS1_reg <= dataBus;
      dataS2_reg <= dataS1_reg;
      weS1_reg   <= writeN;
      weS2_reg   <= weS1_reg;
      weS3_reg   <= weS2_reg;
      pickS1_reg <= {prescale_pick_hi, prescale_pick_lo};
      pickS2_reg <= pickS1_reg;
    end
  end

  // ==========================================================
  // command capture into the fifo
  psg_fifo_if #(.WIDTH(8)) cmdIf ();

  logic       strobeFall;
  logic [7:0] cmd;
  logic       cmdPop;

  assign strobeFall     = weS3_reg && !weS2_reg;
  assign cmdIf.inValid  = strobeFall;
  assign cmdIf.inData   = dataS2_reg;
  assign cmdIf.outReady = 1'b1;
  assign cmdReady       = cmdIf.inReady;
  assign cmd            = cmdIf.outData;
  assign cmdPop         = cmdIf.outValid && cmdIf.outReady;

  psg_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .f     (cmdIf.fifo)
  );

  // ==========================================================
  // register file
  logic [PERIOD_W-1:0] period_reg [NUM_TONE];
  logic [ATT_W-1:0]    att_reg    [NUM_CHAN];
  logic [NCFG_W-1:0]   noiseCfg_reg;
  logic [1:0]          lastCh_reg;
  logic                lastAtt_reg;
  logic                noiseLoad;
  logic [1:0]          cmdCh;

  assign cmdCh     = cmd[CMD_CH_HI:CMD_CH_LO];
  assign noiseLoad = cmdPop && cmd[CMD_LATCH_B] && !cmd[CMD_TYPE_B]
                     && (cmdCh == NOISE_CH);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TONE; i++) begin
        period_reg[i] <= PERIOD_RST;
      end
      for (int i = 0; i < NUM_CHAN; i++) begin
        att_reg[i] <= ATT_RST;
      end
      noiseCfg_reg <= NCFG_RST;
      lastCh_reg   <= '0;
      lastAtt_reg  <= 1'b0;
    end else if (cmdPop) begin
      if (cmd[CMD_LATCH_B]) begin
        lastCh_reg  <= cmdCh;
        lastAtt_reg <= cmd[CMD_TYPE_B];
        if (cmd[CMD_TYPE_B]) begin
          att_reg[cmdCh] <= cmd[ATT_W-1:0];
        end else if (cmdCh == NOISE_CH) begin
          noiseCfg_reg <= cmd[NCFG_W-1:0];
        end else begin
          period_reg[cmdCh][3:0] <= cmd[3:0];
        end
      end else if (!lastAtt_reg && lastCh_reg != NOISE_CH) begin
        period_reg[lastCh_reg][PERIOD_W-1:4] <= cmd[CMD_DATA_HI:0];
      end
    end
  end

  // ==========================================================
  // prescaler
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] prescTop;
  logic               tick;

  always_comb begin
    case (pickS2_reg)
      PICK_DIV1:   prescTop = '0;
      PICK_DIV128: prescTop = PRESC_W'(DIV128 - 1);
      default:     prescTop = PRESC_W'(DIV16 - 1);
    endcase
  end

  assign tick = (presc_reg >= prescTop);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= tick ? '0 : presc_reg + 1'b1;
    end
  end

  // ==========================================================
  // tone generators
  logic [PERIOD_W-1:0] cnt_reg  [NUM_TONE];
  logic [NUM_TONE-1:0] toneBit_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TONE; i++) begin
        cnt_reg[i] <= PERIOD_RST;
      end
      toneBit_reg <= '0;
    end else if (tick) begin
      for (int i = 0; i < NUM_TONE; i++) begin
        if (cnt_reg[i] <= PERIOD_W'(1)) begin
          cnt_reg[i]     <= period_reg[i];
          toneBit_reg[i] <= !toneBit_reg[i];
        end else begin
          cnt_reg[i] <= cnt_reg[i] - 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // noise generator
  logic [LFSR_W-1:0]      lfsr_reg;
  logic [NOISE_CNT_W-1:0] noiseCnt_reg;
  logic [NOISE_CNT_W-1:0] noiseTop;
  logic                   tone2Last_reg;
  logic                   noiseShift;
  logic                   feedback;

  assign noiseTop = NOISE_CNT_W'((NOISE_BASE << noiseCfg_reg[1:0]) - 1);

  always_comb begin
    if (noiseCfg_reg[1:0] == RATE_TONE2) begin
      noiseShift = toneBit_reg[2] && !tone2Last_reg;
    end else begin
      noiseShift = tick && (noiseCnt_reg >= noiseTop);
    end
  end

  assign feedback = noiseCfg_reg[NCFG_WHITE_B] ? (lfsr_reg[0] ^ lfsr_reg[1])
                                               : lfsr_reg[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      noiseCnt_reg  <= '0;
      tone2Last_reg <= 1'b0;
    end else begin
      tone2Last_reg <= toneBit_reg[2];
      if (tick) begin
        noiseCnt_reg <= (noiseCnt_reg >= noiseTop) ? '0
                                                   : noiseCnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lfsr_reg <= LFSR_SEED;
    end else if (noiseLoad) begin
      lfsr_reg <= LFSR_SEED;
    end else if (noiseShift) begin
      lfsr_reg <= {feedback, lfsr_reg[LFSR_W-1:1]};
    end
  end

  // ==========================================================
  // attenuation and mixing
  logic [NUM_CHAN-1:0] chanBit;
  logic [LEVEL_W-1:0]  level [NUM_CHAN];
  logic [SAMPLE_W-1:0] mix;

  assign chanBit = {lfsr_reg[0], toneBit_reg};

  always_comb begin
    mix = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      level[i] = chanBit[i] ? psg_level(att_reg[i]) : '0;
      mix      = mix + SAMPLE_W'(level[i]);
    end
  end

  // ==========================================================
  // outputs: sample and pwm
  logic [SAMPLE_W-1:0] pwmCnt_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample     <= '0;
      pwmCnt_reg <= '0;
      audioPwm   <= 1'b0;
      chanPwm    <= '0;
    end else begin
      sample     <= mix;
      pwmCnt_reg <= pwmCnt_reg + 1'b1;
      audioPwm   <= (sample > pwmCnt_reg);
      for (int i = 0; i < NUM_CHAN; i++) begin
        chanPwm[i] <= (level[i] > pwmCnt_reg[LEVEL_W-1:0]);
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_one_update_low: assert property (
    strobeFall |=> !strobeFall ##1 !strobeFall)
    else $error("two updates from one strobe low");

  a_write_one_cycle: assert property (
    strobeFall && !cmdIf.outValid |=> cmdPop ##1 !cmdIf.outValid)
    else $error("write not completed in one cycle");

  a_att_write: assert property (
    cmdPop && cmd[CMD_LATCH_B] && cmd[CMD_TYPE_B]
    |=> att_reg[$past(cmdCh)] == $past(cmd[ATT_W-1:0]))
    else $error("attenuation not written");

  a_fine_write: assert property (
    cmdPop && cmd[CMD_LATCH_B] && !cmd[CMD_TYPE_B] && cmdCh != NOISE_CH
    |=> period_reg[$past(cmdCh)][3:0] == $past(cmd[3:0]))
    else $error("low period bits not written");

  a_coarse_write: assert property (
    cmdPop && !cmd[CMD_LATCH_B] && !lastAtt_reg && lastCh_reg != NOISE_CH
    |=> period_reg[$past(lastCh_reg)][PERIOD_W-1:4]
        == $past(cmd[CMD_DATA_HI:0]))
    else $error("high period bits not written");

  a_noise_cfg: assert property (
    noiseLoad |=> noiseCfg_reg == $past(cmd[NCFG_W-1:0])
                  && lfsr_reg == LFSR_SEED)
    else $error("noise config not loaded");

  a_tone_reload: assert property (
    tick && cnt_reg[0] <= PERIOD_W'(1)
    |=> cnt_reg[0] == $past(period_reg[0])
        && toneBit_reg[0] != $past(toneBit_reg[0]))
    else $error("tone counter did not reload and flip");

  a_div128_gap: assert property (
    tick && pickS2_reg == PICK_DIV128 && $stable(pickS2_reg)
    |=> !tick [*8])
    else $error("divide by 128 ticks too close");

  a_lfsr_nonzero: assert property (
    lfsr_reg != '0)
    else $error("noise shift register stuck at zero");

  a_silence_zero: assert property (
    chanBit == '0 |=> sample == '0)
    else $error("offset on silent output");

  a_lfsr_shift: assert property (
    noiseShift && !noiseLoad
    |=> lfsr_reg == {$past(feedback), $past(lfsr_reg[LFSR_W-1:1])})
    else $error("noise shift register did not shift");

  a_strobe_push: assert property (
    $fell(weS2_reg) |-> strobeFall && cmdIf.inReady)
    else $error("strobe low period not captured");

  c_noise_load: cover property (noiseLoad);
  c_coarse: cover property (cmdPop && !cmd[CMD_LATCH_B]);
  c_tone_flip: cover property (tick && cnt_reg[1] <= PERIOD_W'(1));
  c_tone2_noise: cover property (
    noiseShift && noiseCfg_reg[1:0] == RATE_TONE2);

endmodule : psg_core
`default_nettype wire

// File: verif/psg_host.sv
// host model: writes command bytes over the parallel bus
// assumes: the design samples dataBus and writeN on the rising clk edge
`timescale 1ns/100ps
`default_nettype none
module psg_host (
  // clock
  input  wire logic       clk,
  // bus pins
  output var  logic [7:0] dataBus,
  output var  logic       writeN
);
  initial begin
    dataBus = 8'h00;
    writeN  = 1'b1;
  end

  // ==========================================================
  // one write: data first, strobe low, strobe high, then data moves
  task automatic send(input logic [7:0] b, input int lowCyc);
    @(negedge clk);
    dataBus <= b;
    repeat (2) @(negedge clk);
    writeN <= 1'b0;
    repeat (lowCyc) @(negedge clk);
    writeN <= 1'b1;
    repeat (2) @(negedge clk);
    dataBus <= ~b;
  endtask : send
endmodule : psg_host
`default_nettype wire

// File: verif/psg_core_tb.sv
// testbench for psg_core: tones, noise, levels, mix and pwm vs model
// assumes: psg_host drives the bus; synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module psg_core_tb;
  import psg_pkg::*;
  logic                clk;
  logic                rst_n;
  logic                pickLo;
  logic                pickHi;
  logic [7:0]          dataBus;
  logic                writeN;
  logic [SAMPLE_W-1:0] sample;
  logic                audioPwm;
  logic [NUM_CHAN-1:0] chanPwm;
  logic                cmdReady;
  int                  mismatches;
  int                  comparisons;
  logic [31:0]         rng;
  logic [14:0]         lfsr;
  int                  n;
  int                  p;
  int                  r;

  psg_core dut (
    .clk              (clk),
    .rst_n            (rst_n),
    .dataBus          (dataBus),
    .writeN           (writeN),
    .prescale_pick_lo (pickLo),
    .prescale_pick_hi (pickHi),
    .sample           (sample),
    .audioPwm         (audioPwm),
    .chanPwm          (chanPwm),
    .cmdReady         (cmdReady)
  );
  psg_host host (.clk(clk), .dataBus(dataBus), .writeN(writeN));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // checking and closing
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // model helpers
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  function automatic int level(input int a);
    return $rtoi(63.0 * (10.0 ** (-a / 10.0)) + 0.5);
  endfunction : level

  task automatic wr(input logic [7:0] b);
    host.send(b, 2);
    repeat (4) @(negedge clk);
    check("cmdReady", cmdReady, 1);
  endtask : wr

  task automatic setAtt(input int c, input int a);
    wr({1'b1, c[1:0], 1'b1, a[3:0]});
  endtask : setAtt

  task automatic setPer(input int c, input int v);
    wr({1'b1, c[1:0], 1'b0, v[3:0]});
    wr({2'b00, v[9:4]});
  endtask : setPer

  task automatic setPick(input int k);
    pickHi <= k[1];
    pickLo <= k[0];
    repeat (4) @(negedge clk);
  endtask : setPick

  // length of the current run of the single loud channel
  task automatic runLen(output int len, input int lim);
    logic cur;
    cur = (sample >= 8'h3F);
    len = 0;
    while ((sample >= 8'h3F) == cur && len <= lim) begin
      @(negedge clk);
      len++;
    end
    if (len > lim) begin
      check("timeout", 1, 0);
      wrap_up();
    end
  endtask : runLen

  task automatic maxPwm(input int c, output int mx);
    int cnt;
    mx = 0;
    repeat (8) begin
      cnt = 0;
      repeat (64) begin
        @(negedge clk);
        cnt += chanPwm[c];
      end
      if (cnt > mx) mx = cnt;
    end
  endtask : maxPwm

  // ==========================================================
  // main sequence
  initial begin
    int ch;
    int dv;
    int aCnt;
    int cs;
    int s;
    int st;
    int lastSt;
    int done;
    rng = 32'h0000_8C11;
    mismatches = 0;
    comparisons = 0;
    rst_n = 1'b0;
    pickLo = 1'b0;
    pickHi = 1'b0;
    repeat (2) @(negedge clk);
    check("sample", sample, 0);
    check("audioPwm", audioPwm, 0);
    check("chanPwm", chanPwm, 0);
    check("cmdReady", cmdReady, 1);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      ch = k % 3;
      p = 3 + rnd() % 14;
      dv = (k == 1) ? 1 : (k == 2) ? 128 : 16;
      setPick(k);
      for (int c = 0; c < 4; c++) setAtt(c, (c == ch) ? 0 : 15);
      setPer(ch, p);
      setAtt(ch, 0);
      wr(8'h3F);
      repeat (3) runLen(n, 64 * dv);
      check("halfPeriod", n, p * dv);
    end
    setPick(1);
    for (int c = 0; c < 3; c++) setPer(c, 200);
    for (int a = 0; a < 16; a++) begin
      setAtt(a % 3, a);
      maxPwm(a % 3, n);
      check("level", n, level(a));
    end
    setPick(2);
    for (int c = 0; c < 4; c++) setAtt(c, 0);
    lastSt = 0;
    done = 0;
    for (int w = 0; w < 20 && done == 0; w++) begin
      s = sample;
      aCnt = 0;
      cs = 0;
      st = 1;
      repeat (256) begin
        @(negedge clk);
        aCnt += audioPwm;
        cs += $countones(chanPwm);
        if (sample !== s) st = 0;
      end
      if (st && lastSt) begin
        check("mixChan", cs % (4 * level(0)), 0);
        check("mixSample", sample, level(0) * (cs / (4 * level(0))));
        check("mixPwm", aCnt, s);
        done = 1;
      end
      lastSt = st;
    end
    if (done == 0) check("mixStable", 0, 1);
    setPick(0);
    setPer(2, 5);
    for (int c = 0; c < 4; c++) setAtt(c, (c == 3) ? 0 : 15);
    for (int code = 0; code < 4; code++) begin
      r = (code == 3) ? 2 * 5 * 16 : 512 << code;
      wr(8'hE0 | code[1:0]);
      runLen(n, 16 * r);
      runLen(n, 2 * r);
      check("noiseRun", n, r);
    end
    setPick(1);
    wr(8'hE4);
    lfsr = LFSR_SEED;
    repeat (14) lfsr = {lfsr[0] ^ lfsr[1], lfsr[14:1]};
    runLen(n, 16 * 32);
    repeat (30) begin
      repeat (16) @(negedge clk);
      check("noiseBit", sample >= 8'h3F, lfsr[0]);
      repeat (16) @(negedge clk);
      lfsr = {lfsr[0] ^ lfsr[1], lfsr[14:1]};
    end
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    check("rstSample", sample, 0);
    check("rstPwm", {audioPwm, chanPwm}, 0);
    rst_n <= 1'b1;
    setPick(2);
    maxPwm(0, n);
    check("rstLevel", n, level(15));
    wrap_up();
  end
endmodule : psg_core_tb
`default_nettype wire
